/* inc/synth_regs_pkg.sv */
// Package: field layout, reset values and encodings of the synthesizer control words
package synth_regs_pkg;
    localparam int WORD_BITS = 32;
    localparam int SEL_BITS = 3;
    // Register select codes
    localparam logic [2:0] SEL_FEEDBACK = 3'h0;
    localparam logic [2:0] SEL_PHASE = 3'h1;
    localparam logic [2:0] SEL_REFERENCE = 3'h2;
    // Register 0 fields
    localparam int NUMER_LSB = 3;
    localparam int NUMER_MSB = 14;
    localparam int INT_LSB = 15;
    localparam int INT_MSB = 30;
    localparam logic [11:0] NUMER_RESET = 12'h000;
    localparam logic [15:0] INT_RESET = 16'h0064;
    // Register 1 fields
    localparam int HOLD_BIT = 28;
    localparam int PHASE_LSB = 15;
    localparam int PHASE_MSB = 26;
    localparam int DENOM_LSB = 3;
    localparam int DENOM_MSB = 14;
    localparam logic [11:0] PHASE_RESET = 12'h001;
    localparam logic [11:0] DENOM_RESET = 12'h002;
    localparam int PHASE_WIDE_SHIFT = 4;
    // Register 2 fields
    localparam int DITHER_LSB = 29;
    localparam int DITHER_MSB = 30;
    localparam int PIN_LSB = 26;
    localparam int PIN_MSB = 28;
    localparam int DOUBLER_BIT = 25;
    localparam int HALVER_BIT = 24;
    localparam int RCOUNT_LSB = 14;
    localparam int RCOUNT_MSB = 23;
    localparam int SHADOW_EN_BIT = 13;
    localparam int PUMP_LSB = 9;
    localparam int PUMP_MSB = 12;
    localparam int LOCK_COUNT_BIT = 8;
    localparam int LOCK_WINDOW_BIT = 7;
    localparam int POLARITY_BIT = 6;
    localparam int SLEEP_BIT = 5;
    localparam int TRISTATE_BIT = 4;
    localparam logic [1:0] DITHER_RESET = 2'h0;
    localparam logic [2:0] PIN_RESET = 3'h0;
    localparam logic [9:0] RCOUNT_RESET = 10'h001;
    localparam logic [3:0] PUMP_RESET = 4'h0;
    localparam logic POLARITY_RESET = 1'b1;
    // Dither codes
    localparam logic [1:0] DITHER_LOW_NOISE = 2'h0;
    localparam logic [1:0] DITHER_LOW_SPUR = 2'h3;
    // Test pin codes
    typedef enum logic [2:0] {
        PIN_HIGHZ = 3'b000,
        PIN_HIGH = 3'b001,
        PIN_LOW = 3'b010,
        PIN_REF_COUNT = 3'b011,
        PIN_FB_COUNT = 3'b100,
        PIN_RESERVED = 3'b101,
        PIN_LOCK = 3'b110,
        PIN_READ_DATA = 3'b111
    } pin_mode_type;
    // Shift state
    typedef enum logic [0:0] {
        SHIFT_IDLE = 1'b0,
        SHIFT_BUSY = 1'b1
    } shift_state_type;
endpackage

/* inc/word_if.sv */
// Interface: completed serial word handed from the shifter to the register bank
`timescale 1ns/1ps
`default_nettype none
interface word_if;
    logic valid;
    logic [31:0] data;
    modport source (output valid, output data);
    modport sink (input valid, input data);
endinterface
`default_nettype wire

/* core/serial_word_shifter.sv */
// Serial shifter that assembles 32-bit words and flags complete ones
`timescale 1ns/1ps
`default_nettype none
module serial_word_shifter
    import synth_regs_pkg::*;
(
    input wire logic clk_in,       // Serial clock domain
    input wire logic rst_b_in,     // Asynchronous reset, active low
    input wire logic clk_en_in,    // Freezes state when low
    input wire logic cs_b_in,      // Chip select, active low
    input wire logic sdi_in,       // Serial data in
    word_if.source word            // Completed word
);
    ////////////////////////////////////////////////////////////////////////
    shift_state_type state, next_state;
    logic [5:0] count, next_count;
    logic [31:0] shift, next_shift;
    logic [31:0] held, next_held;
    logic valid_q, next_valid;

    // Word commits only when select rises after exactly 32 bits
    always_comb begin
        next_state = state;
        next_count = count;
        next_shift = shift;
        next_held = held;
        next_valid = 1'b0;
        if (!cs_b_in) begin
            next_state = SHIFT_BUSY;
            next_shift = {shift[30:0], sdi_in};       // MSB first
            // Saturates past 32 so a very long frame never wraps back to a legal count
            next_count = (count == 6'h21) ? 6'h21 : count + 6'h01;
        end else begin
            next_state = SHIFT_IDLE;
            next_count = 6'h00;
            // A short or overlong frame is dropped without any write
            if (state == SHIFT_BUSY && count == 6'h20) begin
                next_valid = 1'b1;
                next_held = shift;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= SHIFT_IDLE;
            count <= 6'h00;
            shift <= 32'h00000000;
            held <= 32'h00000000;
            valid_q <= 1'b0;
        end else if (clk_en_in) begin
            state <= next_state;
            count <= next_count;
            shift <= next_shift;
            held <= next_held;
            valid_q <= next_valid;
        end
    end

    assign word.valid = valid_q;
    assign word.data = held;
endmodule // serial_word_shifter
`default_nettype wire

/* core/synth_divider_ref_regs.sv */
// Control word bank for the synthesizer feedback divider and reference path
`timescale 1ns/1ps
`default_nettype none
module synth_divider_ref_regs
    import synth_regs_pkg::*;
(
    input wire logic clk_in,                 // Serial clock, 125 MHz max
    input wire logic rst_b_in,               // Asynchronous reset, active low
    input wire logic clk_en_in,              // Clock enable
    input wire logic cs_b_in,                // Chip select, active low
    input wire logic sdi_in,                 // Serial data in
    input wire logic wide_fraction_select_in, // Wide fraction mode
    input wire logic ref_count_in,           // Reference counter output
    input wire logic fb_count_in,            // Feedback counter output
    input wire logic lock_in,                // Lock detect
    input wire logic read_data_in,           // Serial read data
    output logic [15:0] divider_integer_out, // Integer divide value
    output logic [11:0] divider_numerator_out, // Fraction numerator
    output logic [15:0] phase_value_out,     // Scaled phase word
    output logic [11:0] denominator_out,     // Active denominator
    output logic band_search_start_out,      // One-cycle band search pulse
    output logic band_search_hold_out,       // Band search hold
    output logic [1:0] dither_select_out,    // Dither code
    output logic dither_enable_out,          // Dither active
    output logic reference_doubler_out,      // Active doubler
    output logic reference_halver_out,       // Active halver
    output logic [9:0] reference_count_out,  // Active reference ratio
    output logic shadow_update_enable_out,   // Register 4 double-buffer enable
    output logic [3:0] pump_current_code_out, // Active pump current
    output logic lock_count_select_out,      // Lock count select
    output logic lock_window_select_out,     // Lock window select
    output logic detector_polarity_out,      // Detector polarity
    output logic sleep_request_out,          // Power down
    output logic pump_tristate_out,          // Pump high impedance
    output logic test_pin_out,               // Test pin level
    output logic test_pin_oe_out             // Test pin driven
);
    ////////////////////////////////////////////////////////////////////////
    word_if word ();

    // Shifter commits complete words only
    serial_word_shifter shifter (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .clk_en_in(clk_en_in),
        .cs_b_in(cs_b_in),
        .sdi_in(sdi_in),
        .word(word)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [2:0] sel;
    logic wr0, wr1, wr2;
    assign sel = word.data[SEL_BITS-1:0];
    assign wr0 = word.valid && sel == SEL_FEEDBACK;
    assign wr1 = word.valid && sel == SEL_PHASE;
    assign wr2 = word.valid && sel == SEL_REFERENCE;

    // Staged and active field storage
    logic [15:0] integer_q, next_integer;
    logic [11:0] numer_q, next_numer;
    logic hold_q, next_hold;
    logic [11:0] phase_stage, next_phase_stage, phase_q, next_phase;
    logic [11:0] denom_stage, next_denom_stage, denom_q, next_denom;
    logic [1:0] dither_q, next_dither;
    logic [2:0] pin_q, next_pin;
    logic dbl_stage, next_dbl_stage, dbl_q, next_dbl;
    logic half_stage, next_half_stage, half_q, next_half;
    logic [9:0] rc_stage, next_rc_stage, rc_q, next_rc;
    logic shen_q, next_shen;
    logic [3:0] pump_stage, next_pump_stage, pump_q, next_pump;
    logic [4:0] misc_q, next_misc;
    logic start_q, next_start;

    // Only defined fields are captured; reserved bits fall away
    always_comb begin
        next_integer = integer_q;
        next_numer = numer_q;
        next_hold = hold_q;
        next_phase_stage = phase_stage;
        next_denom_stage = denom_stage;
        next_dither = dither_q;
        next_pin = pin_q;
        next_dbl_stage = dbl_stage;
        next_half_stage = half_stage;
        next_rc_stage = rc_stage;
        next_shen = shen_q;
        next_pump_stage = pump_stage;
        next_misc = misc_q;
        next_phase = phase_q;
        next_denom = denom_q;
        next_dbl = dbl_q;
        next_half = half_q;
        next_rc = rc_q;
        next_pump = pump_q;
        next_start = 1'b0;
        if (wr1) begin
            next_hold = word.data[HOLD_BIT];
            next_phase_stage = word.data[PHASE_MSB:PHASE_LSB];
            next_denom_stage = word.data[DENOM_MSB:DENOM_LSB];
        end
        if (wr2) begin
            next_dither = word.data[DITHER_MSB:DITHER_LSB];
            next_pin = word.data[PIN_MSB:PIN_LSB];
            next_dbl_stage = word.data[DOUBLER_BIT];
            next_half_stage = word.data[HALVER_BIT];
            next_rc_stage = word.data[RCOUNT_MSB:RCOUNT_LSB];
            next_shen = word.data[SHADOW_EN_BIT];
            next_pump_stage = word.data[PUMP_MSB:PUMP_LSB];
            next_misc = word.data[LOCK_COUNT_BIT:TRISTATE_BIT];
        end
        if (wr0) begin
            next_integer = word.data[INT_MSB:INT_LSB];
            next_numer = word.data[NUMER_MSB:NUMER_LSB];
            // Staged values move to the active set on a register 0 write
            next_phase = phase_stage;
            next_denom = denom_stage;
            next_dbl = dbl_stage;
            next_half = half_stage;
            next_rc = rc_stage;
            next_pump = pump_stage;
            next_start = !hold_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            integer_q <= INT_RESET;
            numer_q <= NUMER_RESET;
            hold_q <= 1'b0;
            phase_stage <= PHASE_RESET;
            phase_q <= PHASE_RESET;
            denom_stage <= DENOM_RESET;
            denom_q <= DENOM_RESET;
            dither_q <= DITHER_RESET;
            pin_q <= PIN_RESET;
            dbl_stage <= 1'b0;
            dbl_q <= 1'b0;
            half_stage <= 1'b0;
            half_q <= 1'b0;
            rc_stage <= RCOUNT_RESET;
            rc_q <= RCOUNT_RESET;
            shen_q <= 1'b0;
            pump_stage <= PUMP_RESET;
            pump_q <= PUMP_RESET;
            misc_q <= {4'h0, 1'b0} | {2'h0, POLARITY_RESET, 2'h0};
            start_q <= 1'b0;
        end else if (clk_en_in) begin
            integer_q <= next_integer;
            numer_q <= next_numer;
            hold_q <= next_hold;
            phase_stage <= next_phase_stage;
            phase_q <= next_phase;
            denom_stage <= next_denom_stage;
            denom_q <= next_denom;
            dither_q <= next_dither;
            pin_q <= next_pin;
            dbl_stage <= next_dbl_stage;
            dbl_q <= next_dbl;
            half_stage <= next_half_stage;
            half_q <= next_half;
            rc_stage <= next_rc_stage;
            rc_q <= next_rc;
            shen_q <= next_shen;
            pump_stage <= next_pump_stage;
            pump_q <= next_pump;
            misc_q <= next_misc;
            start_q <= next_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test pin multiplexer; reserved code parks the pin undriven
    always_comb begin
        test_pin_out = 1'b0;
        test_pin_oe_out = 1'b1;
        case (pin_mode_type'(pin_q))
            PIN_HIGHZ: test_pin_oe_out = 1'b0;
            PIN_HIGH: test_pin_out = 1'b1;
            PIN_LOW: test_pin_out = 1'b0;
            PIN_REF_COUNT: test_pin_out = ref_count_in;
            PIN_FB_COUNT: test_pin_out = fb_count_in;
            PIN_LOCK: test_pin_out = lock_in;
            PIN_READ_DATA: test_pin_out = read_data_in;
            default: test_pin_oe_out = 1'b0;
        endcase
    end

    // Wide mode weighs each phase step by 16
    assign phase_value_out = wide_fraction_select_in ?
        {phase_q, 4'h0} : {4'h0, phase_q};
    assign dither_enable_out = (dither_q == DITHER_LOW_SPUR);
    assign divider_integer_out = integer_q;
    assign divider_numerator_out = numer_q;
    assign denominator_out = denom_q;
    assign band_search_start_out = start_q;
    assign band_search_hold_out = hold_q;
    assign dither_select_out = dither_q;
    assign reference_doubler_out = dbl_q;
    assign reference_halver_out = half_q;
    assign reference_count_out = rc_q;
    assign shadow_update_enable_out = shen_q;
    assign pump_current_code_out = pump_q;
    assign lock_count_select_out = misc_q[4];
    assign lock_window_select_out = misc_q[3];
    assign detector_polarity_out = misc_q[2];
    assign sleep_request_out = misc_q[1];
    assign pump_tristate_out = misc_q[0];
endmodule // synth_divider_ref_regs
`default_nettype wire

/* verification/regs_checker.sv */
// Checker: timing and field relations at the control word bank ports
`timescale 1ns/1ps
`default_nettype none
module regs_checker (
    input wire logic clk_in,                      // Serial clock
    input wire logic rst_b_in,                    // Reset, active low
    input wire logic cs_b_in,                     // Chip select, active low
    input wire logic wide_fraction_select_in,     // Wide fraction mode
    input wire logic [15:0] divider_integer_out,  // Integer value
    input wire logic [11:0] divider_numerator_out, // Numerator
    input wire logic [15:0] phase_value_out,      // Scaled phase
    input wire logic [11:0] denominator_out,      // Denominator
    input wire logic band_search_start_out,       // Band search pulse
    input wire logic band_search_hold_out,        // Band search hold
    input wire logic [1:0] dither_select_out,     // Dither code
    input wire logic dither_enable_out,           // Dither active
    input wire logic reference_doubler_out,       // Doubler
    input wire logic reference_halver_out,        // Halver
    input wire logic [9:0] reference_count_out,   // Reference ratio
    input wire logic [3:0] pump_current_code_out  // Pump current
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////
    // Shadowed fields as one vector; phase left out since it also follows the wide pin
    logic [27:0] shadowed;
    assign shadowed = {denominator_out, reference_doubler_out, reference_halver_out,
                       reference_count_out, pump_current_code_out};
    ////////////////////////////////////////
    chk_reset_values: assert property ($rose(rst_b_in) |-> denominator_out == 12'h002
        && reference_count_out == 10'h001 && divider_numerator_out == 12'h000
        && !reference_doubler_out && !reference_halver_out)
        else $error("reset values wrong");
    chk_pulse_single: assert property (band_search_start_out |=> !band_search_start_out)
        else $error("band search pulse too long");
    // Pulse comes two edges after the commit edge, so the last frame bit lies three edges back
    chk_pulse_after_frame: assert property (band_search_start_out |-> $past(cs_b_in, 2) && !$past(cs_b_in, 3))
        else $error("band search pulse not after a frame");
    chk_pulse_unheld: assert property (band_search_start_out |-> !band_search_hold_out)
        else $error("band search started while held");
    chk_dither_decode: assert property (dither_enable_out == (dither_select_out == 2'h3))
        else $error("dither enable mismatch");
    chk_phase_weight: assert property (
        (wide_fraction_select_in ? phase_value_out[3:0] : phase_value_out[15:12]) == 4'h0)
        else $error("phase weight wrong");
    // A frame may start right after a commit edge, so its first bit is left out
    chk_quiet_in_frame: assert property (!cs_b_in && !$past(cs_b_in) |=> $stable(shadowed)
        && $stable(divider_integer_out) && $stable(dither_select_out))
        else $error("outputs moved inside a frame");
    chk_shadow_on_reg0: assert property (
        $changed(shadowed) && !band_search_hold_out |-> band_search_start_out)
        else $error("shadowed field applied without feedback write");
endmodule // regs_checker
bind synth_divider_ref_regs regs_checker u_chk (.clk_in, .rst_b_in, .cs_b_in, .wide_fraction_select_in,
    .divider_integer_out, .divider_numerator_out, .phase_value_out, .denominator_out,
    .band_search_start_out, .band_search_hold_out, .dither_select_out, .dither_enable_out,
    .reference_doubler_out, .reference_halver_out, .reference_count_out, .pump_current_code_out);
`default_nettype wire

/* verification/host_spi_model.sv */
// Host-side serial master model that shifts control words into the bank
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
    input wire logic clk_in,  // Serial clock
    output logic cs_b_out,    // Chip select, active low
    output logic sdi_out      // Serial data
);
    // Idle with the bank deselected
    initial begin
        cs_b_out = 1'h1;
        sdi_out = 1'h0;
    end
    ////////////////////////////////////////
    // Shifts n bits MSB first; lengths other than 32 give a frame the bank must drop
    task automatic send(input logic [31:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in);
            cs_b_out <= 1'h0;
            sdi_out <= w[31 - (i % 32)];
        end
        @(negedge clk_in);
        cs_b_out <= 1'h1;
        sdi_out <= ~sdi_out; // Released line must not look like held data
    endtask
endmodule // host_spi_model
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the synthesizer control word bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import synth_regs_pkg::*;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic wide = 1'h0;
    logic [3:0] src = 4'h0;
    logic en = 1'h1;
    logic cs_b, sdi, start_o, hold_o, dith_en_o, dbl_o, hlv_o, sh_o, lc_o, lw_o, pol_o, slp_o, tris_o, pin_o, oe_o;
    logic [15:0] int_o, phase_o, act;
    logic [11:0] num_o, den_o;
    logic [9:0] rc_o;
    logic [3:0] pump_o;
    logic [1:0] dith_o;
    integer errors = 0;
    integer n_checks = 0;
    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end
    synth_divider_ref_regs u_dut (.clk_in(clk), .rst_b_in(rst_b), .clk_en_in(en), .cs_b_in(cs_b),
        .sdi_in(sdi), .wide_fraction_select_in(wide), .ref_count_in(src[3]), .fb_count_in(src[2]),
        .lock_in(src[1]), .read_data_in(src[0]), .divider_integer_out(int_o), .divider_numerator_out(num_o),
        .phase_value_out(phase_o), .denominator_out(den_o), .band_search_start_out(start_o),
        .band_search_hold_out(hold_o), .dither_select_out(dith_o), .dither_enable_out(dith_en_o),
        .reference_doubler_out(dbl_o), .reference_halver_out(hlv_o), .reference_count_out(rc_o),
        .shadow_update_enable_out(sh_o), .pump_current_code_out(pump_o), .lock_count_select_out(lc_o),
        .lock_window_select_out(lw_o), .detector_polarity_out(pol_o), .sleep_request_out(slp_o),
        .pump_tristate_out(tris_o), .test_pin_out(pin_o), .test_pin_oe_out(oe_o));
    host_spi_model u_host (.clk_in(clk), .cs_b_out(cs_b), .sdi_out(sdi));
    ////////////////////////////////////////
    task automatic complete_run();
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One frame, then the pulse is looked at in its single cycle and after it
    task automatic put(input logic [31:0] w, input int n, input logic st);
        u_host.send(w, n);
        repeat (2) @(negedge clk);
        chk(start_o, st);
        @(negedge clk);
        chk(start_o, 1'h0);
    endtask
    // Word builders; select codes kept legal by each builder, reserved bits set to ones
    function automatic logic [31:0] w0(input logic [15:0] a, input logic [11:0] b);
        return {1'h1, a, b, SEL_FEEDBACK};
    endfunction
    function automatic logic [31:0] w1(input logic h, input logic [11:0] p, input logic [11:0] d);
        return {3'h7, h, 1'h1, p, d, SEL_PHASE};
    endfunction
    function automatic logic [31:0] w2(input logic [2:0] i, input logic [15:0] s);
        return {1'h1, i[1:0], i, s[15:14], s[13:4], i[0], s[3:0], i[0], i[1], i[2], ~i[0], i[1], 1'h1,
                SEL_REFERENCE};
    endfunction
    // Expected {enable, level} of the test pin per code
    function automatic logic [1:0] pin_exp(input logic [2:0] c);
        case (c)
            3'h1: return 2'h3;
            3'h2: return 2'h2;
            3'h3: return {1'h1, src[3]};
            3'h4: return {1'h1, src[2]};
            3'h6: return {1'h1, src[1]};
            3'h7: return {1'h1, src[0]};
            default: return 2'h0;
        endcase
    endfunction
    ////////////////////////////////////////
    task automatic t_reset();
        chk({int_o, num_o}, {16'h0064, 12'h000});
        chk({phase_o, den_o}, {16'h0001, 12'h002});
        chk({dbl_o, hlv_o, rc_o}, {2'h0, 10'h001});
        chk({dith_o, pol_o, oe_o, hold_o}, 5'h04);
    endtask
    // Short, long and unmapped frames leave everything alone
    task automatic t_drop();
        put(w0(16'h1234, 12'hABC), 31, 1'h0);
        put(w0(16'h1234, 12'hABC), 33, 1'h0);
        for (int s = 3; s < 8; s++) put({29'h1FFFFFFF, 3'(s)}, 32, 1'h0);
        chk({int_o, num_o, den_o}, {16'h0064, 12'h000, 12'h002});
    endtask
    task automatic t_reg1();
        put(w1(1'h0, 12'hA5C, 12'h3E7), 32, 1'h0);
        chk({phase_o, den_o, int_o}, {16'h0001, 12'h002, 16'h0064});
        put(w0(16'hC0DE, 12'h5A3), 32, 1'h1);
        chk({int_o, num_o}, {16'hC0DE, 12'h5A3});
        chk({phase_o, den_o}, {16'h0A5C, 12'h3E7});
        wide = 1'h1;
        @(negedge clk);
        chk(phase_o, 16'hA5C0);
        wide = 1'h0;
    endtask
    task automatic t_hold();
        put(w1(1'h1, 12'h001, 12'hFFF), 32, 1'h0);
        chk(hold_o, 1'h1);
        put(w0(16'h0008, 12'h000), 32, 1'h0);
        chk({int_o, den_o}, {16'h0008, 12'hFFF});
        put(w1(1'h0, 12'h001, 12'h002), 32, 1'h0);
        chk(hold_o, 1'h0);
    endtask
    // With the clock enable low a complete frame must leave no trace
    task automatic t_freeze();
        en = 1'h0;
        put(w0(16'h0100, 12'h0FF), 32, 1'h0);
        en = 1'h1;
        chk({int_o, num_o}, {16'h0008, 12'h000});
    endtask
    // Every dither and pin code; shadowed fields move only on feedback writes
    task automatic t_reg2();
        logic [15:0] s;
        act = 16'h0010;
        for (int k = 0; k < 8; k++) begin
            s = {k[1], k[2], 10'h2B0 + 10'(k), 4'h9 ^ 4'(k)};
            put(w2(3'(k), s), 32, 1'h0);
            chk({dith_o, dith_en_o, sh_o, lc_o, lw_o, pol_o, slp_o, tris_o},
                {k[1:0], k[1:0] == 2'h3, k[0], k[0], k[1], k[2], ~k[0], k[1]});
            chk({dbl_o, hlv_o, rc_o, pump_o}, act);
            for (int p = 0; p < 2; p++) begin
                src = p ? 4'hA : 4'h5;
                @(negedge clk);
                chk({oe_o, oe_o ? pin_o : 1'h0}, pin_exp(3'(k)));
            end
            if (k[1:0] == 2'h3) begin
                put(w0(16'h0040, 12'h001), 32, 1'h1);
                act = s;
                chk({dbl_o, hlv_o, rc_o, pump_o}, act);
            end
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'h1;
        t_reset();
        t_drop();
        t_reg1();
        t_hold();
        t_freeze();
        t_reg2();
        complete_run();
    end
    // Watchdog well beyond the roughly 850 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire
